/* inc/slpic_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SLPIC_CONSTS_SVH
`define SLPIC_CONSTS_SVH
`define SLPIC_OFS_LPR       8'h00
`define SLPIC_OFS_IER       8'h04
`define SLPIC_OFS_IDR       8'h08
`define SLPIC_OFS_IMR       8'h0c
`define SLPIC_OFS_ISR       8'h10
`define SLPIC_OFS_MDR       8'h14
`define SLPIC_LPCFG_LSB     0
`define SLPIC_PARR_LSB      4
`define SLPIC_TCR_LSB       8
`define SLPIC_DRV_LSB       10
`define SLPIC_TMO_LSB       12
`define SLPIC_RFERR_BIT     0
`define SLPIC_LPR_RST       32'h0000_0000
`define SLPIC_MDR_RST       2'h0
`define SLPIC_MT_SDR        2'h0
`define SLPIC_MT_LP         2'h1
`define SLPIC_LPCFG_OFF     2'h0
`define SLPIC_LPCFG_SR      2'h1
`define SLPIC_LPCFG_PD      2'h2
`define SLPIC_LPCFG_DPD     2'h3
`define SLPIC_TMO_NOW       2'h0
`define SLPIC_TMO_64        2'h1
`define SLPIC_TMO_128       2'h2
`define SLPIC_TMO_RSVD      2'h3
`define SLPIC_IDLE_64       8'd64
`define SLPIC_IDLE_128      8'd128
`endif

/* inc/slpic_pkg.sv */
// types for the low-power and interrupt block
package slpic_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } slpic_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } slpic_apb_rsp_t;
  typedef struct packed {
    logic [1:0] drive_strength;
    logic [1:0] temp_comp_refresh;
    logic [2:0] partial_array_refresh;
  } slpic_ext_mode_t;
  typedef enum logic [2:0] {
    SLPIC_CMD_NONE = 3'b000,
    SLPIC_CMD_SELF_REFRESH = 3'b001,
    SLPIC_CMD_POWER_DOWN = 3'b010,
    SLPIC_CMD_DEEP_PD = 3'b011,
    SLPIC_CMD_EXIT = 3'b100
  } slpic_cmd_t;
  typedef enum logic [2:0] {
    SLPIC_ST_BUSY = 3'b000,
    SLPIC_ST_WAIT = 3'b001,
    SLPIC_ST_LOW = 3'b010,
    SLPIC_ST_WAKE = 3'b011,
    SLPIC_ST_HOLD = 3'b100
  } slpic_state_t;
endpackage

/* verilog/slpic_top.sv */
// sdram low-power entry, init parameter load and refresh-error interrupt
`include "slpic_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - at init send partial-array setting (quarter, half or all banks) to memory.
// - in self-refresh issue no refresh to excluded banks; controller refresh held off.
// - at init send temperature-compensated self-refresh setting to memory.
// - at init send drive-strength setting to memory.
// - those three settings apply to low-power memory only, never standard sdram.
// - timeout 00 enters low-power mode right after the final transfer.
// - timeout 01 enters low-power mode 64 cycles after the final transfer.
// - timeout 10 enters after 128 cycles; 11 is reserved.
// - writing 1 to enable bit 0 enables refresh-error interrupt; 0 no effect.
// - writing 1 to disable bit 0 disables refresh-error interrupt; 0 no effect.
// - mask bit 0 reads 1 while interrupt enabled, 0 while disabled.
// - status bit reads 1 if refresh error since last read; reading clears it.
// - config 01 self-refresh, clock stopped, clock-enable low; exit per access.
// - config 10 power-down after access, enable low; 00 issues no low-power command.
module slpic_top (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // apb slave
  input  wire slpic_pkg::slpic_apb_req_t apb_req,
  output      slpic_pkg::slpic_apb_rsp_t apb_rsp,
  // controller side
  input  wire logic                     init_start,
  input  wire logic                     xfer_busy,
  input  wire logic                     access_req,
  input  wire logic                     refresh_error,
  // memory parameter load
  output      logic                     ext_mode_load,
  output      slpic_pkg::slpic_ext_mode_t ext_mode_value,
  // low-power control
  output      slpic_pkg::slpic_cmd_t    lp_cmd,
  output      logic                     mem_clock_enable,
  output      logic                     mem_clock_run,
  output      logic                     refresh_allow,
  output      logic                     access_grant,
  // interrupt
  output      logic                     irq
);
  import slpic_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  logic srst_n;
  assign srst_n = rst_sync_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        setup;
  logic        wr_done;
  logic        rd_done;
  logic        hit;
  logic [7:0]  addr;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  assign addr = apb_req.paddr;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_done = apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite;
  assign rd_done = apb_req.psel && apb_req.penable && pready_r && !apb_req.pwrite;
  always_comb begin
    hit = 1'b0;
    case (addr)
      `SLPIC_OFS_LPR: hit = 1'b1;
      `SLPIC_OFS_IER: hit = 1'b1;
      `SLPIC_OFS_IDR: hit = 1'b1;
      `SLPIC_OFS_IMR: hit = 1'b1;
      `SLPIC_OFS_ISR: hit = 1'b1;
      `SLPIC_OFS_MDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] lp_cfg_r;
  logic [2:0] pa_refresh_r;
  logic [1:0] tc_refresh_r;
  logic [1:0] drv_str_r;
  logic [1:0] tmo_r;
  logic [1:0] mtype_r;
  logic       mask_r;
  logic       status_r;
  logic       is_lp_mem;
  assign is_lp_mem = (mtype_r == `SLPIC_MT_LP);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_cfg_r     <= 2'(`SLPIC_LPR_RST >> `SLPIC_LPCFG_LSB);
      pa_refresh_r <= 3'h0;
      tc_refresh_r <= 2'h0;
      drv_str_r    <= 2'h0;
      tmo_r        <= 2'h0;
    end else if (!srst_n) begin
      lp_cfg_r     <= 2'h0;
      pa_refresh_r <= 3'h0;
      tc_refresh_r <= 2'h0;
      drv_str_r    <= 2'h0;
      tmo_r        <= 2'h0;
    end else if (wr_done && addr == `SLPIC_OFS_LPR) begin
      lp_cfg_r     <= apb_req.pwdata[`SLPIC_LPCFG_LSB +: 2];
      pa_refresh_r <= apb_req.pwdata[`SLPIC_PARR_LSB +: 3];
      tc_refresh_r <= apb_req.pwdata[`SLPIC_TCR_LSB +: 2];
      drv_str_r    <= apb_req.pwdata[`SLPIC_DRV_LSB +: 2];
      tmo_r        <= apb_req.pwdata[`SLPIC_TMO_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mtype_r <= `SLPIC_MDR_RST;
    end else if (!srst_n) begin
      mtype_r <= `SLPIC_MDR_RST;
    end else if (wr_done && addr == `SLPIC_OFS_MDR) begin
      mtype_r <= apb_req.pwdata[1:0];
    end
  end

  // enable and disable both written at once cannot happen: they are separate words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 1'b0;
    end else if (!srst_n) begin
      mask_r <= 1'b0;
    end else if (wr_done && addr == `SLPIC_OFS_IER && apb_req.pwdata[`SLPIC_RFERR_BIT]) begin
      mask_r <= 1'b1;
    end else if (wr_done && addr == `SLPIC_OFS_IDR && apb_req.pwdata[`SLPIC_RFERR_BIT]) begin
      mask_r <= 1'b0;
    end
  end

  // a new error in the clearing read cycle survives the clear
  // only a bit the read returned is cleared: an error at the setup edge is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 1'b0;
    end else if (!srst_n) begin
      status_r <= 1'b0;
    end else if (refresh_error) begin
      status_r <= 1'b1;
    end else if (rd_done && addr == `SLPIC_OFS_ISR) begin
      status_r <= status_r && !prdata_r[`SLPIC_RFERR_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (!srst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= status_r && mask_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: no wait state; read data comes from a flop loaded in the setup cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `SLPIC_OFS_LPR: begin
        rd_mux[`SLPIC_LPCFG_LSB +: 2] = lp_cfg_r;
        rd_mux[`SLPIC_PARR_LSB +: 3]  = pa_refresh_r;
        rd_mux[`SLPIC_TCR_LSB +: 2]   = tc_refresh_r;
        rd_mux[`SLPIC_DRV_LSB +: 2]   = drv_str_r;
        rd_mux[`SLPIC_TMO_LSB +: 2]   = tmo_r;
      end
      `SLPIC_OFS_IMR: rd_mux[`SLPIC_RFERR_BIT] = mask_r;
      `SLPIC_OFS_ISR: rd_mux[`SLPIC_RFERR_BIT] = status_r;
      `SLPIC_OFS_MDR: rd_mux[1:0] = mtype_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (!srst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    // ready stands one cycle; a master lingering in access sees no second ready
    end else if (setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= !hit;
      prdata_r  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
  end
  assign apb_rsp = '{prdata:  prdata_r,
                     pready:  pready_r,
                     pslverr: pslverr_r};

  //////////////////////////////////////////////////////////////////////////////
  // init parameter load, low-power memory only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_mode_load  <= 1'b0;
      ext_mode_value <= '0;
    end else if (!srst_n) begin
      ext_mode_load  <= 1'b0;
      ext_mode_value <= '0;
    end else begin
      ext_mode_load <= init_start && is_lp_mem;
      if (init_start && is_lp_mem) begin
        ext_mode_value.partial_array_refresh <= pa_refresh_r;
        ext_mode_value.temp_comp_refresh     <= tc_refresh_r;
        ext_mode_value.drive_strength        <= drv_str_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-power sequencer
  slpic_state_t state_r;
  slpic_state_t state_nxt;
  logic [7:0]   idle_cnt_r;
  logic [7:0]   idle_lim;
  logic         lp_on;
  logic         tmo_ok;
  logic         idle;
  slpic_cmd_t   enter_cmd;
  logic         in_sr_r;

  // deep power-down is a low-power-memory mode; on standard sdram it stays off
  assign lp_on = (lp_cfg_r == `SLPIC_LPCFG_SR) || (lp_cfg_r == `SLPIC_LPCFG_PD) ||
                 (lp_cfg_r == `SLPIC_LPCFG_DPD && is_lp_mem);
  assign tmo_ok = (tmo_r != `SLPIC_TMO_RSVD);
  assign idle = !xfer_busy && !access_req;

  // reserved timeout never counts down, so the memory simply stays awake
  always_comb begin
    idle_lim = 8'd0;
    case (tmo_r)
      `SLPIC_TMO_NOW: idle_lim = 8'd0;
      `SLPIC_TMO_64:  idle_lim = `SLPIC_IDLE_64;
      `SLPIC_TMO_128: idle_lim = `SLPIC_IDLE_128;
      default:        idle_lim = 8'd0;
    endcase
  end

  always_comb begin
    enter_cmd = SLPIC_CMD_NONE;
    case (lp_cfg_r)
      `SLPIC_LPCFG_SR:  enter_cmd = SLPIC_CMD_SELF_REFRESH;
      `SLPIC_LPCFG_PD:  enter_cmd = SLPIC_CMD_POWER_DOWN;
      `SLPIC_LPCFG_DPD: enter_cmd = SLPIC_CMD_DEEP_PD;
      default:         enter_cmd = SLPIC_CMD_NONE;
    endcase
  end

  // any traffic while counting restarts it, so entry always follows the last transfer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SLPIC_ST_BUSY: begin
        if (idle && lp_on && tmo_ok) begin
          state_nxt = (idle_lim == 8'd0) ? SLPIC_ST_LOW : SLPIC_ST_WAIT;
        end
      end
      SLPIC_ST_WAIT: begin
        if (!idle || !lp_on) begin
          state_nxt = SLPIC_ST_BUSY;
        end else if (idle_cnt_r == idle_lim - 8'd1) begin
          state_nxt = SLPIC_ST_LOW;
        end
      end
      SLPIC_ST_LOW: begin
        state_nxt = SLPIC_ST_HOLD;
      end
      SLPIC_ST_HOLD: begin
        if (access_req || !lp_on) begin
          state_nxt = SLPIC_ST_WAKE;
        end
      end
      SLPIC_ST_WAKE: begin
        state_nxt = SLPIC_ST_BUSY;
      end
      default: state_nxt = SLPIC_ST_BUSY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SLPIC_ST_BUSY;
    end else if (!srst_n) begin
      state_r <= SLPIC_ST_BUSY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counts idle cycles from the first idle one after the transfer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r <= 8'd0;
    end else if (!srst_n) begin
      idle_cnt_r <= 8'd0;
    end else if (state_nxt == SLPIC_ST_WAIT && state_r == SLPIC_ST_BUSY) begin
      idle_cnt_r <= 8'd1;
    end else if (state_r == SLPIC_ST_WAIT) begin
      idle_cnt_r <= idle_cnt_r + 8'd1;
    end else begin
      idle_cnt_r <= 8'd0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory-side outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_cmd           <= SLPIC_CMD_NONE;
      mem_clock_enable <= 1'b1;
      mem_clock_run    <= 1'b1;
      in_sr_r          <= 1'b0;
      access_grant     <= 1'b0;
    end else if (!srst_n) begin
      lp_cmd           <= SLPIC_CMD_NONE;
      mem_clock_enable <= 1'b1;
      mem_clock_run    <= 1'b1;
      in_sr_r          <= 1'b0;
      access_grant     <= 1'b0;
    end else begin
      lp_cmd       <= SLPIC_CMD_NONE;
      access_grant <= (state_r == SLPIC_ST_BUSY) && access_req && !xfer_busy;
      if (state_r == SLPIC_ST_LOW) begin
        lp_cmd           <= enter_cmd;
        mem_clock_enable <= 1'b0;
        mem_clock_run    <= (enter_cmd != SLPIC_CMD_SELF_REFRESH);
        in_sr_r          <= (enter_cmd == SLPIC_CMD_SELF_REFRESH);
      end else if (state_r == SLPIC_ST_WAKE) begin
        lp_cmd           <= SLPIC_CMD_EXIT;
        mem_clock_enable <= 1'b1;
        mem_clock_run    <= 1'b1;
        in_sr_r          <= 1'b0;
      end
    end
  end

  // memory refreshes itself (enabled banks only) while in self-refresh
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_allow <= 1'b0;
    end else if (!srst_n) begin
      refresh_allow <= 1'b0;
    end else begin
      refresh_allow <= !in_sr_r && state_r != SLPIC_ST_LOW && state_r != SLPIC_ST_HOLD;
    end
  end
endmodule

/* verif/slpic_mem_model.sv */
// behavioural low-power sdram partner
module slpic_mem_model (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // from controller
  input  wire logic                       ext_mode_load,
  input  wire slpic_pkg::slpic_ext_mode_t ext_mode_value,
  input  wire slpic_pkg::slpic_cmd_t      lp_cmd,
  input  wire logic                       refresh_allow,
  // observation
  output      slpic_pkg::slpic_ext_mode_t mode_r,
  output      int                         loads,
  output      int                         bad_refresh
);
  import slpic_pkg::*;
  logic self_ref;
  // exit clears first so a stray entry pulse stays visible
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= '0;
      loads <= 0;
      bad_refresh <= 0;
      self_ref <= 1'b0;
    end else begin
      if (ext_mode_load) begin
        mode_r <= ext_mode_value;
        loads <= loads + 1;
      end
      if (lp_cmd == SLPIC_CMD_EXIT) self_ref <= 1'b0;
      else if (lp_cmd == SLPIC_CMD_SELF_REFRESH) self_ref <= 1'b1;
      if (self_ref && refresh_allow) bad_refresh <= bad_refresh + 1;
    end
  end
endmodule

/* verif/slpic_top_chk.sv */
// port assertions of the low-power and interrupt block
`include "slpic_consts.svh"
module slpic_top_chk (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // apb
  input  wire slpic_pkg::slpic_apb_req_t  apb_req,
  input  wire slpic_pkg::slpic_apb_rsp_t  apb_rsp,
  // controller side
  input  wire logic                       init_start,
  input  wire logic                       xfer_busy,
  input  wire logic                       access_req,
  input  wire logic                       refresh_error,
  // memory side
  input  wire logic                       ext_mode_load,
  input  wire slpic_pkg::slpic_cmd_t      lp_cmd,
  input  wire logic                       mem_clock_enable,
  input  wire logic                       mem_clock_run,
  input  wire logic                       refresh_allow,
  input  wire logic                       irq
);
  import slpic_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic isr_rd;
  assign isr_rd = apb_req.psel & apb_req.penable & apb_rsp.pready & !apb_req.pwrite
                  & (apb_req.paddr == `SLPIC_OFS_ISR);
  ////////////////////////////////////////
  property p_load;
    ext_mode_load |-> $past(init_start);
  endproperty
  a_load: assert property (p_load) else $error("mode load without init");
  property p_sr;
    lp_cmd == SLPIC_CMD_SELF_REFRESH |-> !mem_clock_enable && !mem_clock_run;
  endproperty
  a_sr: assert property (p_sr) else $error("self-refresh with clock on");
  property p_norefresh;
    !mem_clock_run |-> !refresh_allow;
  endproperty
  a_norefresh: assert property (p_norefresh) else $error("refresh in self-refresh");
  property p_pd;
    lp_cmd == SLPIC_CMD_POWER_DOWN |-> !mem_clock_enable && mem_clock_run;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down levels wrong");
  property p_idle;
    lp_cmd inside {SLPIC_CMD_SELF_REFRESH, SLPIC_CMD_POWER_DOWN}
      |-> !$past(xfer_busy, 2) && !$past(access_req, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("low power entered while busy");
  property p_pulse;
    lp_cmd != SLPIC_CMD_NONE |=> lp_cmd == SLPIC_CMD_NONE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command longer than one cycle");
  property p_exit;
    lp_cmd == SLPIC_CMD_EXIT |-> mem_clock_enable && mem_clock_run;
  endproperty
  a_exit: assert property (p_exit) else $error("exit with clock off");
  property p_wake;
    !mem_clock_enable && access_req |-> ##[1:4] mem_clock_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on access");
  property p_irqclr;
    isr_rd && !refresh_error && !$past(refresh_error) |-> ##2 !irq;
  endproperty
  a_irqclr: assert property (p_irqclr) else $error("irq stays after status read");
  property p_ready;
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready late");
endmodule
bind slpic_top slpic_top_chk u_chk (.ref_clk, .rst_n, .apb_req, .apb_rsp, .init_start, .xfer_busy,
  .access_req, .refresh_error, .ext_mode_load, .lp_cmd, .mem_clock_enable, .mem_clock_run,
  .refresh_allow, .irq);

/* verif/test_slpic_top.sv */
// self-checking bench for the low-power and interrupt block
`include "slpic_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_slpic_top;
  timeunit 1ns;
  timeprecision 1ps;
  import slpic_pkg::*;
  logic ref_clk, rst_n, init_start, xfer_busy, access_req, refresh_error;
  logic ext_mode_load, mem_clock_enable, mem_clock_run, refresh_allow, access_grant, irq;
  slpic_apb_req_t  req;
  slpic_apb_rsp_t  rsp;
  slpic_ext_mode_t ext_mode_value, mode_r;
  slpic_cmd_t      lp_cmd;
  int miscompares = 0, checks = 0, cyc = 0, loads, bad_refresh;
  logic [31:0] rdat;
  logic        rerr;
  slpic_top u_dut (.ref_clk, .rst_n, .apb_req(req), .apb_rsp(rsp), .init_start, .xfer_busy,
    .access_req, .refresh_error, .ext_mode_load, .ext_mode_value, .lp_cmd, .mem_clock_enable,
    .mem_clock_run, .refresh_allow, .access_grant, .irq);
  slpic_mem_model u_mem (.ref_clk, .rst_n, .ext_mode_load, .ext_mode_value, .lp_cmd,
    .refresh_allow, .mode_r, .loads, .bad_refresh);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang in any wait ends here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask
  task automatic pulse(input int which);
    @(posedge ref_clk);
    if (which == 0) init_start <= 1'b1;
    else refresh_error <= 1'b1;
    @(posedge ref_clk);
    init_start <= 1'b0;
    refresh_error <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // n counts edges from the idle edge until clock-enable drops, 300 if never
  task automatic lp_try(input logic [1:0] cfg, input logic [1:0] tmo, input int exp);
    int n;
    apb(1'b1, `SLPIC_OFS_LPR, {18'h0, tmo, 10'h0, cfg});
    @(posedge ref_clk);
    xfer_busy <= 1'b0;
    for (n = 1; n < 300; n++) begin
      @(posedge ref_clk);
      #1;
      if (mem_clock_enable !== 1'b1) break;
    end
    `CHK("entry", exp, n)
    `CHK("clk_run", (cfg != `SLPIC_LPCFG_SR || n == 300), mem_clock_run)
    @(posedge ref_clk);
    access_req <= 1'b1;
    do @(posedge ref_clk); while (access_grant !== 1'b1);
    `CHK("woken", 1'b1, mem_clock_enable)
    access_req <= 1'b0;
    xfer_busy <= 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    init_start = 1'b0;
    xfer_busy = 1'b1;
    access_req = 1'b0;
    refresh_error = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk("lpr", `SLPIC_OFS_LPR, 32'h0);
    rchk("mdr", `SLPIC_OFS_MDR, 32'h0);
    rchk("imr", `SLPIC_OFS_IMR, 32'h0);
    rchk("isr", `SLPIC_OFS_ISR, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    `CHK("slverr", 1'b1, rerr)
    rchk("unmapped", 8'h18, 32'h0);
    pulse(0);
    `CHK("loads", 0, loads)
    apb(1'b1, `SLPIC_OFS_MDR, 32'h1);
    apb(1'b1, `SLPIC_OFS_LPR, 32'h0000_0950);
    pulse(0);
    `CHK("mode", 7'h4d, mode_r)
    `CHK("loads", 1, loads)
    apb(1'b1, `SLPIC_OFS_IER, 32'h0);
    rchk("imr", `SLPIC_OFS_IMR, 32'h0);
    apb(1'b1, `SLPIC_OFS_IER, 32'h1);
    apb(1'b1, `SLPIC_OFS_IMR, 32'h0);
    rchk("imr", `SLPIC_OFS_IMR, 32'h1);
    apb(1'b1, `SLPIC_OFS_IDR, 32'h0);
    rchk("imr", `SLPIC_OFS_IMR, 32'h1);
    pulse(1);
    `CHK("irq", 1'b1, irq)
    rchk("isr", `SLPIC_OFS_ISR, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK("irq", 1'b0, irq)
    rchk("isr", `SLPIC_OFS_ISR, 32'h0);
    apb(1'b1, `SLPIC_OFS_IDR, 32'h1);
    rchk("imr", `SLPIC_OFS_IMR, 32'h0);
    pulse(1);
    `CHK("irq", 1'b0, irq)
    rchk("isr", `SLPIC_OFS_ISR, 32'h1);
    // error lands on the setup edge of a status read: must survive that read
    fork
      apb(1'b0, `SLPIC_OFS_ISR, 32'h0);
      begin
        @(posedge ref_clk);
        refresh_error <= 1'b1;
        @(posedge ref_clk);
        refresh_error <= 1'b0;
      end
    join
    `CHK("isr_race", 32'h0, rdat)
    rchk("isr_kept", `SLPIC_OFS_ISR, 32'h1);
    lp_try(`SLPIC_LPCFG_SR, `SLPIC_TMO_NOW, 2);
    lp_try(`SLPIC_LPCFG_SR, `SLPIC_TMO_64, 65);
    lp_try(`SLPIC_LPCFG_SR, `SLPIC_TMO_128, 129);
    lp_try(`SLPIC_LPCFG_SR, `SLPIC_TMO_RSVD, 300);
    lp_try(`SLPIC_LPCFG_PD, `SLPIC_TMO_NOW, 2);
    lp_try(`SLPIC_LPCFG_OFF, `SLPIC_TMO_NOW, 300);
    lp_try(`SLPIC_LPCFG_DPD, `SLPIC_TMO_NOW, 2);
    apb(1'b1, `SLPIC_OFS_MDR, 32'h0);
    lp_try(`SLPIC_LPCFG_DPD, `SLPIC_TMO_NOW, 300);
    `CHK("refresh", 0, bad_refresh)
    results();
  end
endmodule
